// *** hw/capture_channel.sv ***
// one timer channel: input capture, value register, read coherency, event flag
`timescale 1ns/1ps
`default_nettype none
`include "timer_regs.svh"
module capture_channel
    import timer_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    chan_if.chan     ch
);
    logic   pin_d_reg;
    count_t value_reg;
    count_t snap_reg;
    latch_e latch_reg;
    logic   is_cap;
    logic   rise;
    logic   fall;
    logic   hit;
    logic   flag_next;
    logic   live;

    assign is_cap = !ch.center && (ch.mode == `MODE_CAPTURE);
    assign rise = ch.pin & ~pin_d_reg;
    assign fall = ~ch.pin & pin_d_reg;
    // edge select 00 leaves the pin disconnected; halt does not gate capture
    assign hit = is_cap && ((ch.edge_sel[`EDGE_RISE_BIT] && rise) ||
                 (ch.edge_sel[`EDGE_FALL_BIT] && fall));
    assign flag_next = hit | (ch.flag & ~ch.flag_clr);
    assign live = ch.halt || (latch_reg == LATCH_IDLE);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_d_reg <= 1'b0;
            value_reg <= `COUNT_RESET;
        end else begin
            pin_d_reg <= ch.pin;
            if (hit) begin
                value_reg <= ch.count;
            end else if (!is_cap && ch.hi_wr) begin
                value_reg[15:8] <= ch.wdata;
            end else if (!is_cap && ch.lo_wr) begin
                value_reg[7:0] <= ch.wdata;
            end
        end
    end

    // read coherency; frozen in halt so a half-done read survives it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_reg <= LATCH_IDLE;
            snap_reg  <= `COUNT_RESET;
        end else if (ch.ctrl_wr) begin
            latch_reg <= LATCH_IDLE;
        end else if (!ch.halt) begin
            case (latch_reg)
                LATCH_IDLE: begin
                    if (ch.hi_rd) begin
                        snap_reg  <= value_reg;
                        latch_reg <= WAIT_LO;
                    end else if (ch.lo_rd) begin
                        snap_reg  <= value_reg;
                        latch_reg <= WAIT_HI;
                    end
                end
                WAIT_LO: if (ch.lo_rd) latch_reg <= LATCH_IDLE;
                WAIT_HI: if (ch.hi_rd) latch_reg <= LATCH_IDLE;
                default: latch_reg <= LATCH_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ch.hi_q <= `BYTE_RESET;
            ch.lo_q <= `BYTE_RESET;
        end else begin
            if (ch.hi_rd) ch.hi_q <= live ? value_reg[15:8] : snap_reg[15:8];
            if (ch.lo_rd) ch.lo_q <= live ? value_reg[7:0] : snap_reg[7:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ch.flag <= 1'b0;
            ch.irq  <= 1'b0;
        end else begin
            ch.flag <= flag_next;
            ch.irq  <= flag_next & ch.ie;
        end
    end

    chk_capture_value: assert property (
        @(posedge sys_clk) disable iff (!rst_n) hit |=> value_reg == $past(ch.count))
        else $error("capture did not store the counter");
    chk_capture_flag: assert property (
        @(posedge sys_clk) disable iff (!rst_n) hit |=> ch.flag && ch.irq == $past(ch.ie))
        else $error("capture did not raise the flag");
    chk_capture_readonly: assert property (
        @(posedge sys_clk) disable iff (!rst_n) (is_cap && !hit && (ch.hi_wr || ch.lo_wr)) |=> $stable(value_reg))
        else $error("capture value changed by a write");
    chk_ctrl_release: assert property (
        @(posedge sys_clk) disable iff (!rst_n) ch.ctrl_wr |=> latch_reg == LATCH_IDLE)
        else $error("control write left the latch held");
endmodule // capture_channel
`default_nettype wire

// *** hw/chan_if.sv ***
// carrier between the counter core and one capture channel
`timescale 1ns/1ps
`default_nettype none
interface chan_if;
    import timer_pkg::*;
    count_t     count;
    logic       center;
    logic       halt;
    logic       pin;
    logic [1:0] mode;
    logic [1:0] edge_sel;
    logic       ie;
    logic       ctrl_wr;
    logic       flag_clr;
    logic       hi_rd;
    logic       lo_rd;
    logic       hi_wr;
    logic       lo_wr;
    byte_t      wdata;
    byte_t      hi_q;
    byte_t      lo_q;
    logic       flag;
    logic       irq;
    modport core (output count, center, halt, pin, mode, edge_sel, ie, ctrl_wr,
                  flag_clr, hi_rd, lo_rd, hi_wr, lo_wr, wdata,
                  input hi_q, lo_q, flag, irq);
    modport chan (input count, center, halt, pin, mode, edge_sel, ie, ctrl_wr,
                  flag_clr, hi_rd, lo_rd, hi_wr, lo_wr, wdata,
                  output hi_q, lo_q, flag, irq);
endinterface
`default_nettype wire

// *** hw/timer_counter_input_capture.sv ***
// timer counter core with clock select, prescaler, overflow and capture channels
`timescale 1ns/1ps
`default_nettype none
`include "timer_regs.svh"
module timer_counter_input_capture
    import timer_pkg::*;
(
    input  wire logic                      sys_clk,
    input  wire logic                      rst_n,
    input  wire logic [1:0]                clock_source_select,
    input  wire logic [`PSC_W-1:0]         prescale_select,
    input  wire logic                      center_align_select,
    input  wire logic                      overflow_irq_enable,
    input  wire logic [15:0]               modulus_value,
    input  wire logic                      pll_engaged,
    input  wire logic                      fixed_clk,
    input  wire logic [`CH_IDX_W-1:0]      ext_clk_channel,
    input  wire logic                      debug_halt_mode,
    input  wire logic                      overflow_flag_clear,
    input  wire logic                      counter_write,
    input  wire logic                      counter_high_read,
    input  wire logic                      counter_low_read,
    input  wire logic [`NUM_CHAN-1:0]      chan_pin,
    input  wire logic [`NUM_CHAN-1:0]      channel_mode_bit_hi,
    input  wire logic [`NUM_CHAN-1:0]      channel_mode_bit_lo,
    input  wire logic [2*`NUM_CHAN-1:0]    edge_level_select,
    input  wire logic [`NUM_CHAN-1:0]      chan_irq_enable,
    input  wire logic [`NUM_CHAN-1:0]      channel_control_write,
    input  wire logic [`NUM_CHAN-1:0]      channel_flag_clear,
    input  wire logic [`NUM_CHAN-1:0]      value_high_read,
    input  wire logic [`NUM_CHAN-1:0]      value_low_read,
    input  wire logic [`NUM_CHAN-1:0]      value_high_write,
    input  wire logic [`NUM_CHAN-1:0]      value_low_write,
    input  wire logic [7:0]                write_data,
    output var  logic [15:0]               counter_value,
    output var  logic                      count_down,
    output var  logic [7:0]                counter_high_byte,
    output var  logic [7:0]                counter_low_byte,
    output var  logic                      overflow_flag,
    output var  logic                      overflow_irq,
    output wire logic [8*`NUM_CHAN-1:0]    channel_value_high,
    output wire logic [8*`NUM_CHAN-1:0]    channel_value_low,
    output wire logic [`NUM_CHAN-1:0]      channel_event_flag,
    output wire logic [`NUM_CHAN-1:0]      channel_irq
);

    // ************************************************************
    // declarations
    // ************************************************************
    count_t                 count_reg;
    logic                   down_reg;
    logic [`PSC_CNT_W-1:0]  psc_reg;
    logic [`PSC_CNT_W-1:0]  psc_last;
    logic                   fix_s1_reg;
    logic                   fix_s2_reg;
    logic                   fix_d_reg;
    logic                   ext_d_reg;
    logic [`NUM_CHAN-1:0]   pin_sync;
    logic                   fix_rise;
    logic                   ext_rise;
    logic                   src_tick;
    logic                   tick;
    count_t                 term;
    logic                   at_term;
    logic                   ovf_set;
    logic                   ovf_next;
    count_t                 snap_reg;
    latch_e                 latch_reg;
    logic                   live;

    // ************************************************************
    // clock source selection and synchronisers
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fix_s1_reg <= 1'b0;
            fix_s2_reg <= 1'b0;
            fix_d_reg  <= 1'b0;
        end else begin
            fix_s1_reg <= fixed_clk;
            fix_s2_reg <= fix_s1_reg;
            fix_d_reg  <= fix_s2_reg;
        end
    end

    // ext clock shares the already synchronised channel pin
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_d_reg <= 1'b0;
        end else begin
            ext_d_reg <= pin_sync[ext_clk_channel];
        end
    end

    assign fix_rise = fix_s2_reg & ~fix_d_reg;
    // edge detect needs a pin held two cycles, hence the divide-by-four limit
    assign ext_rise = pin_sync[ext_clk_channel] & ~ext_d_reg;

    always_comb begin
        case (clk_src_e'(clock_source_select))
            CLK_OFF:   src_tick = 1'b0;
            CLK_BUS:   src_tick = 1'b1;
            CLK_FIXED: src_tick = pll_engaged ? fix_rise : 1'b1;
            CLK_EXT:   src_tick = ext_rise;
            default:   src_tick = 1'b0;
        endcase
    end

    // ************************************************************
    // prescaler: divide by two to the power of the select
    // ************************************************************
    assign psc_last = (`PSC_CNT_W'(1) << prescale_select) - `PSC_CNT_W'(1);
    assign tick = src_tick && !debug_halt_mode && (psc_reg >= psc_last);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            psc_reg <= '0;
        end else if (counter_write) begin
            psc_reg <= '0;
        end else if (src_tick && !debug_halt_mode) begin
            if (psc_reg >= psc_last) begin
                psc_reg <= '0;
            end else begin
                psc_reg <= psc_reg + `PSC_CNT_W'(1);
            end
        end
    end

    // ************************************************************
    // main counter
    // ************************************************************
    // modulus zero means free running to 0xffff
    assign term = (modulus_value == `COUNT_RESET) ? `COUNT_TOP : modulus_value;
    assign at_term = (count_reg == term);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= `COUNT_RESET;
            down_reg  <= 1'b0;
        end else if (counter_write) begin
            count_reg <= `COUNT_RESET;
            down_reg  <= 1'b0;
        end else if (tick) begin
            if (!center_align_select) begin
                down_reg <= 1'b0;
                if (at_term) begin
                    count_reg <= `COUNT_RESET;
                end else begin
                    count_reg <= count_reg + `COUNT_ONE;
                end
            end else if (!down_reg) begin
                if (at_term) begin
                    count_reg <= count_reg - `COUNT_ONE;
                    down_reg  <= 1'b1;
                end else begin
                    count_reg <= count_reg + `COUNT_ONE;
                end
            end else begin
                if (count_reg == `COUNT_RESET) begin
                    count_reg <= `COUNT_ONE;
                    down_reg  <= 1'b0;
                end else begin
                    count_reg <= count_reg - `COUNT_ONE;
                end
            end
        end
    end

    // ************************************************************
    // overflow flag and interrupt
    // ************************************************************
    assign ovf_set = tick && !counter_write && at_term &&
                     (!center_align_select || !down_reg);
    // a set in the clearing cycle wins so no overflow is lost
    assign ovf_next = ovf_set | (overflow_flag & ~overflow_flag_clear);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            overflow_flag <= 1'b0;
            overflow_irq  <= 1'b0;
        end else begin
            overflow_flag <= ovf_next;
            overflow_irq  <= ovf_next & overflow_irq_enable;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_value <= `COUNT_RESET;
            count_down    <= 1'b0;
        end else begin
            counter_value <= count_reg;
            count_down    <= down_reg;
        end
    end

    // ************************************************************
    // counter read coherency
    // ************************************************************
    assign live = debug_halt_mode || (latch_reg == LATCH_IDLE);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_reg <= LATCH_IDLE;
            snap_reg  <= `COUNT_RESET;
        end else if (counter_write) begin
            latch_reg <= LATCH_IDLE;
        end else if (!debug_halt_mode) begin
            case (latch_reg)
                LATCH_IDLE: begin
                    if (counter_high_read) begin
                        snap_reg  <= count_reg;
                        latch_reg <= WAIT_LO;
                    end else if (counter_low_read) begin
                        snap_reg  <= count_reg;
                        latch_reg <= WAIT_HI;
                    end
                end
                WAIT_LO: if (counter_low_read) latch_reg <= LATCH_IDLE;
                WAIT_HI: if (counter_high_read) latch_reg <= LATCH_IDLE;
                default: latch_reg <= LATCH_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_high_byte <= `BYTE_RESET;
            counter_low_byte  <= `BYTE_RESET;
        end else begin
            if (counter_high_read) begin
                counter_high_byte <= live ? count_reg[15:8] : snap_reg[15:8];
            end
            if (counter_low_read) begin
                counter_low_byte <= live ? count_reg[7:0] : snap_reg[7:0];
            end
        end
    end

    // ************************************************************
    // channels
    // ************************************************************
    // channel on the ext clock pin must not be set for capture by software
    generate
        for (genvar i = 0; i < `NUM_CHAN; i++) begin : g_ch
            logic s1_reg;
            logic s2_reg;
            chan_if bus ();

            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                end else begin
                    s1_reg <= chan_pin[i];
                    s2_reg <= s1_reg;
                end
            end

            assign pin_sync[i]   = s2_reg;
            assign bus.count     = count_reg;
            assign bus.center    = center_align_select;
            assign bus.halt      = debug_halt_mode;
            assign bus.pin       = s2_reg;
            assign bus.mode      = {channel_mode_bit_hi[i], channel_mode_bit_lo[i]};
            assign bus.edge_sel  = edge_level_select[2*i +: 2];
            assign bus.ie        = chan_irq_enable[i];
            assign bus.ctrl_wr   = channel_control_write[i];
            assign bus.flag_clr  = channel_flag_clear[i];
            assign bus.hi_rd     = value_high_read[i];
            assign bus.lo_rd     = value_low_read[i];
            assign bus.hi_wr     = value_high_write[i];
            assign bus.lo_wr     = value_low_write[i];
            assign bus.wdata     = write_data;

            capture_channel u_ch (
                .sys_clk (sys_clk),
                .rst_n   (rst_n),
                .ch      (bus.chan)
            );

            assign channel_value_high[8*i +: 8] = bus.hi_q;
            assign channel_value_low[8*i +: 8]  = bus.lo_q;
            assign channel_event_flag[i]        = bus.flag;
            assign channel_irq[i]               = bus.irq;
        end
    endgenerate

    // ************************************************************
    // checks
    // ************************************************************
    chk_clock_off_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (clock_source_select == 2'b00 && !counter_write) |=> $stable(count_reg))
        else $error("counter moved with clock off");
    chk_up_wrap: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (tick && !counter_write && !center_align_select && at_term)
        |=> count_reg == `COUNT_RESET && overflow_flag)
        else $error("up count did not wrap with overflow");
    chk_center_turn: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (tick && !counter_write && center_align_select && !down_reg && at_term)
        |=> down_reg && count_reg == $past(count_reg) - `COUNT_ONE && overflow_flag)
        else $error("center turn did not set overflow");
    chk_center_bottom: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (tick && !counter_write && center_align_select && down_reg &&
         count_reg == `COUNT_RESET) |=> !down_reg && count_reg == `COUNT_ONE)
        else $error("center bottom did not turn up");
    chk_ovf_level: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        overflow_irq == (overflow_flag && $past(overflow_irq_enable)))
        else $error("overflow request not level of flag and enable");
    chk_counter_clear: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        counter_write |=> count_reg == `COUNT_RESET && latch_reg == LATCH_IDLE)
        else $error("counter write did not clear");
    chk_halt_freeze: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (debug_halt_mode && !counter_write) |=> $stable(count_reg))
        else $error("counter moved in debug halt");
    chk_ext_step: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (clock_source_select == 2'b11 && tick) |->
        ($past(chan_pin[ext_clk_channel], 2) && !$past(chan_pin[ext_clk_channel], 3)))
        else $error("external step without synchronised edge");
endmodule // timer_counter_input_capture
`default_nettype wire

// *** hw/timer_pkg.sv ***
// types shared by the timer counter and its capture channels
package timer_pkg;
    typedef logic [15:0] count_t;
    typedef logic [7:0]  byte_t;
    typedef enum logic [1:0] {CLK_OFF, CLK_BUS, CLK_FIXED, CLK_EXT} clk_src_e;
    typedef enum logic [1:0] {LATCH_IDLE, WAIT_LO, WAIT_HI} latch_e;
endpackage

// *** hw/timer_regs.svh ***
// field positions, reset values and counts for the timer counter
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

`define NUM_CHAN      2
`define CH_IDX_W      1
`define CLKSEL_RESET  2'b00
`define PSC_W         3
`define PSC_CNT_W     8
`define COUNT_RESET   16'h0000
`define COUNT_TOP     16'hffff
`define COUNT_ONE     16'h0001
`define BYTE_RESET    8'h00
`define EDGE_RISE_BIT 0
`define EDGE_FALL_BIT 1
`define MODE_CAPTURE  2'b00
`define EXT_DIV_MIN   4

`endif

// *** verif/pin_driver.sv ***
// far-side model: channel pin events and external clock source
`timescale 1ns/1ps
`default_nettype none
module pin_driver (
    input  wire logic       sys_clk,
    output var  logic [1:0] pins
);
    initial pins = 2'b00;
    // *****
    // pulse
    // *****
    // five bus cycles a period when called back to back, never faster than bus over four
    task automatic pulse(input int ch);
        @(negedge sys_clk);
        pins[ch] = 1'b1;
        repeat (2) @(negedge sys_clk);
        pins[ch] = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask
endmodule // pin_driver
`default_nettype wire

// *** verif/timer_counter_input_capture_tb.sv ***
// bench for the timer counter with input capture
`timescale 1ns/1ps
`default_nettype none
module timer_counter_input_capture_tb;
    import timer_pkg::*;
    // *****
    // wiring
    // *****
    logic        sys_clk = 0, rst_n = 0, center_align_select = 0, overflow_irq_enable = 0;
    logic        pll_engaged = 0, fixed_clk = 0, ext_clk_channel = 1, debug_halt_mode = 0;
    logic        overflow_flag_clear = 0, counter_write = 0;
    logic        counter_high_read = 0, counter_low_read = 0;
    logic [1:0]  clock_source_select = 0, chan_pin, channel_mode_bit_hi = 0;
    logic [1:0]  channel_mode_bit_lo = 0, chan_irq_enable = 0, channel_control_write = 0;
    logic [1:0]  channel_flag_clear = 0, value_high_read = 0, value_low_read = 0;
    logic [1:0]  value_high_write = 0, value_low_write = 0;
    logic [1:0]  channel_event_flag, channel_irq;
    logic [2:0]  prescale_select = 0;
    logic [3:0]  edge_level_select = 0;
    logic [7:0]  write_data = 0, counter_high_byte, counter_low_byte, b;
    logic [15:0] modulus_value = 0, counter_value, channel_value_high, channel_value_low, v;
    logic        overflow_flag, overflow_irq, count_down;
    int          fails = 0, tests_run = 0;
    logic [15:0] center_seq [4] = '{16'h0001, 16'h0000, 16'h0001, 16'h0002};
    timer_counter_input_capture dut (.*);
    pin_driver pins (.sys_clk(sys_clk), .pins(chan_pin));
    initial forever #20 sys_clk = ~sys_clk;
    // *****
    // tasks
    // *****
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input bit hi, output logic [7:0] d);
        if (hi) value_high_read[0] = 1'b1;
        else value_low_read[0] = 1'b1;
        tick(1);
        value_high_read = 2'b00;
        value_low_read = 2'b00;
        tick(1);
        d = hi ? channel_value_high[7:0] : channel_value_low[7:0];
    endtask
    task automatic crd(input bit hi);
        if (hi) counter_high_read = 1'b1;
        else counter_low_read = 1'b1;
        tick(1);
        counter_high_read = 1'b0;
        counter_low_read = 1'b0;
        tick(1);
    endtask
    task automatic close_out;
        $display("tests_run %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #100us;
        fails++;
        close_out;
    end
    // *****
    // tests
    // *****
    initial begin
        tick(16);
        rst_n = 1'b1;
        tick(20);
        check(counter_value, 16'h0000);
        check(overflow_flag, 1'b0);
        $display("test reset done");
        // ch1 carries the clock, so its edge select stays disconnected
        clock_source_select = 2'b11;
        edge_level_select = 4'b0001;
        chan_irq_enable = 2'b01;
        repeat (5) pins.pulse(1);
        tick(4);
        check(counter_value, 16'h0005);
        check(channel_event_flag, 2'b00);
        pins.pulse(0);
        tick(4);
        check(channel_event_flag, 2'b01);
        check(channel_irq, 2'b01);
        write_data = 8'haa;
        value_low_write[0] = 1'b1;
        tick(1);
        value_low_write = 2'b00;
        rd(0, b);
        check(b, 8'h05);
        rd(1, b);
        check(b, 8'h00);
        channel_mode_bit_lo = 2'b01;
        value_low_write[0] = 1'b1;
        tick(1);
        value_low_write = 2'b00;
        rd(0, b);
        check(b, 8'haa);
        channel_mode_bit_lo = 2'b00;
        channel_flag_clear[0] = 1'b1;
        tick(1);
        channel_flag_clear = 2'b00;
        check(channel_event_flag, 2'b00);
        // latch still holds 0x00aa; the control write frees it without a high read
        pins.pulse(1);
        pins.pulse(0);
        channel_control_write[0] = 1'b1;
        tick(1);
        channel_control_write = 2'b00;
        rd(0, b);
        check(b, 8'h06);
        pins.pulse(1);
        debug_halt_mode = 1'b1;
        pins.pulse(1);
        pins.pulse(0);
        rd(0, b);
        check(b, 8'h07);
        debug_halt_mode = 1'b0;
        $display("test capture done");
        clock_source_select = 2'b01;
        crd(0);
        check(counter_low_byte, 8'h07);
        tick(300);
        crd(1);
        check(counter_high_byte, 8'h00);
        crd(0);
        counter_write = 1'b1;
        tick(1);
        counter_write = 1'b0;
        crd(1);
        check(counter_high_byte, 8'h00);
        clock_source_select = 2'b11;
        $display("test counter read done");
        counter_write = 1'b1;
        tick(1);
        counter_write = 1'b0;
        tick(2);
        check(counter_value, 16'h0000);
        modulus_value = 16'h0003;
        overflow_irq_enable = 1'b1;
        clock_source_select = 2'b01;
        for (int i = 0; i < 20 && overflow_flag !== 1'b1; i++) tick(1);
        check(overflow_irq, 1'b1);
        for (int i = 0; i < 10; i++) begin
            tick(1);
            check(counter_value <= 16'h0003, 1'b1);
        end
        overflow_irq_enable = 1'b0;
        tick(1);
        check(overflow_irq, 1'b0);
        check(overflow_flag, 1'b1);
        clock_source_select = 2'b00;
        overflow_flag_clear = 1'b1;
        tick(1);
        overflow_flag_clear = 1'b0;
        check(overflow_flag, 1'b0);
        clock_source_select = 2'b01;
        $display("test overflow done");
        center_align_select = 1'b1;
        modulus_value = 16'h0002;
        counter_write = 1'b1;
        overflow_flag_clear = 1'b1;
        tick(1);
        counter_write = 1'b0;
        overflow_flag_clear = 1'b0;
        // one more cycle so the stale count before the clear is gone
        tick(1);
        for (int i = 0; i < 20 && counter_value !== 16'h0002; i++) tick(1);
        check(overflow_flag, 1'b1);
        for (int i = 0; i < 4; i++) begin
            tick(1);
            check(counter_value, center_seq[i]);
            check(count_down, i < 2);
        end
        clock_source_select = 2'b00;
        tick(2);
        v = counter_value;
        tick(10);
        check(counter_value, v);
        $display("test center and stop done");
        center_align_select = 1'b0;
        modulus_value = 16'h0000;
        counter_write = 1'b1;
        tick(1);
        counter_write = 1'b0;
        // fixed source without a locked loop ticks every bus cycle
        clock_source_select = 2'b10;
        prescale_select = 3'h2;
        tick(40);
        clock_source_select = 2'b00;
        tick(2);
        check(counter_value, 16'h000a);
        counter_write = 1'b1;
        pll_engaged = 1'b1;
        prescale_select = 3'h0;
        tick(1);
        counter_write = 1'b0;
        clock_source_select = 2'b10;
        repeat (6) begin
            fixed_clk = 1'b1;
            tick(2);
            fixed_clk = 1'b0;
            tick(2);
        end
        tick(4);
        clock_source_select = 2'b00;
        tick(2);
        check(counter_value, 16'h0006);
        $display("test clock sources done");
        close_out;
    end
endmodule // timer_counter_input_capture_tb
`default_nettype wire
